// >>> logic/alss_consts.svh
// Register offsets, field positions, clock rate and timing counts
`ifndef ALSS_CONSTS_SVH
`define ALSS_CONSTS_SVH
`define ALSS_CLK_MHZ 10
`define ALSS_SRST_WAIT_NS 1000
`define ALSS_SRST_CYCLES ((`ALSS_SRST_WAIT_NS * `ALSS_CLK_MHZ + 999) / 1000)
`define ALSS_OFS_CTRL 12'h000
`define ALSS_OFS_LINK 12'h004
`define ALSS_OFS_CAL 12'h008
`define ALSS_OFS_STAT 12'h00C
`define ALSS_CTRL_SRST 0
`define ALSS_CTRL_LINK_EN 1
`define ALSS_CTRL_CAL_EN 2
`define ALSS_CTRL_OVERRANGE_ENABLE 3
`define ALSS_CTRL_TRIG 4
`define ALSS_CTRL_DUAL 5
`define ALSS_LINK_FMT_LSB 0
`define ALSS_LINK_KM1_LSB 8
`define ALSS_LINK_SYNC_SEL 16
`define ALSS_CAL_BG 0
`define ALSS_CAL_OFS 1
`define ALSS_CAL_TIME 8'h40
`endif

// >>> logic/alss_pkg.sv
// Types for the link startup sequencer
package alss_pkg;
    typedef enum logic [1:0] {
        LINK_HALT,
        LINK_WAIT_SYNC,
        LINK_UP
    } alss_link_type;
    typedef enum logic [1:0] {
        CAL_HALT,
        CAL_IDLE,
        CAL_RUN
    } alss_cal_type;
endpackage

// >>> logic/alss_sequencer.sv
// Link and calibration startup sequencer with APB register port
`timescale 1ns/1ns
`include "alss_consts.svh"
// Summary of operation
// - Link enable at zero halts the link machine so settings can change.
// - Calibration enable at zero halts the calibration machine.
// - Sync source chooses single-ended sync input or timestamp inputs.
// - Calibration enable at one restarts the calibration machine.
// - Link enable at one restarts the link machine.
// - The restarted link follows the receiver's SYNC request.
// - A zero-to-one change of the trigger bit starts a calibration while the calibration machine is idle.
// - Single-channel mode uses dual-edge sampling at the same clock.
module alss_sequencer
    import alss_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sync request inputs, active low
    input wire logic single_ended_sync_input_n,
    input wire logic timestamp_sync_n,
    // Device state towards the core
    output logic link_running,
    output logic link_data_valid,
    output logic cal_busy,
    output logic dual_edge_sampling,
    output logic overrange_enable,
    output logic soft_reset_active
);
    localparam logic [7:0] SRST_CYC = 8'(`ALSS_SRST_CYCLES);

    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [31:0] link_ff, nxt_link;
    logic [1:0] cal_opt_ff, nxt_cal_opt;
    logic [7:0] srst_cnt_ff, nxt_srst_cnt;
    logic [7:0] cal_cnt_ff, nxt_cal_cnt;
    logic trig_q_ff, nxt_trig_q;
    logic cal_done_ff, nxt_cal_done;
    logic [31:0] prdata_ff, nxt_prdata;
    alss_link_type link_st_ff, nxt_link_st;
    alss_cal_type cal_st_ff, nxt_cal_st;

    logic acc, wr, rd, hit, sync_req_n;
    logic serial_link_enable, calibration_enable, calibration_trigger_bit;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    // Read data loads in setup, so it already stands in the access cycle
    assign rd = psel && !penable && !pwrite;
    assign hit = (paddr == `ALSS_OFS_CTRL) || (paddr == `ALSS_OFS_LINK) ||
                 (paddr == `ALSS_OFS_CAL) || (paddr == `ALSS_OFS_STAT);
    // Zero-wait slave; a write is taken on the access edge
    assign pready = acc;
    assign pslverr = acc && !hit;
    assign prdata = prdata_ff;

    assign serial_link_enable = ctrl_ff[`ALSS_CTRL_LINK_EN];
    assign calibration_enable = ctrl_ff[`ALSS_CTRL_CAL_EN];
    assign calibration_trigger_bit = ctrl_ff[`ALSS_CTRL_TRIG];
    // Sync source mux: 0 single-ended pin, 1 timestamp pair
    assign sync_req_n = link_ff[`ALSS_LINK_SYNC_SEL] ? timestamp_sync_n
                                                     : single_ended_sync_input_n;
    // Single channel when dual bit is clear: sample on both edges
    assign dual_edge_sampling = !ctrl_ff[`ALSS_CTRL_DUAL];
    assign overrange_enable = ctrl_ff[`ALSS_CTRL_OVERRANGE_ENABLE];
    assign soft_reset_active = (srst_cnt_ff != 8'h00);
    assign link_running = (link_st_ff != LINK_HALT);
    assign link_data_valid = (link_st_ff == LINK_UP);
    assign cal_busy = (cal_st_ff == CAL_RUN);

    // Register file and soft reset timer
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_link = link_ff;
        nxt_cal_opt = cal_opt_ff;
        nxt_srst_cnt = srst_cnt_ff;
        nxt_prdata = prdata_ff;
        if (srst_cnt_ff != 8'h00) begin
            nxt_srst_cnt = srst_cnt_ff - 8'h01;
        end
        if (wr && paddr == `ALSS_OFS_CTRL) begin
            nxt_ctrl = {26'h0, pwdata[5:1], 1'b0};
            // Software reset returns settings to defaults, then waits
            if (pwdata[`ALSS_CTRL_SRST]) begin
                nxt_ctrl = 32'h0000_0006;
                nxt_link = 32'h0;
                nxt_cal_opt = 2'h0;
                nxt_srst_cnt = SRST_CYC;
            end
        end
        if (wr && paddr == `ALSS_OFS_LINK) begin
            nxt_link = {15'h0, pwdata[16:8], 3'h0, pwdata[4:0]};
        end
        if (wr && paddr == `ALSS_OFS_CAL) begin
            nxt_cal_opt = pwdata[1:0];
        end
        if (rd) begin
            unique case (paddr)
                `ALSS_OFS_CTRL: nxt_prdata = ctrl_ff;
                `ALSS_OFS_LINK: nxt_prdata = link_ff;
                `ALSS_OFS_CAL: nxt_prdata = {30'h0, cal_opt_ff};
                `ALSS_OFS_STAT: nxt_prdata = {26'h0, cal_done_ff,
                    soft_reset_active, cal_busy, link_data_valid,
                    link_running, sync_req_n};
                default: nxt_prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_ff <= 32'h0000_0006;
            link_ff <= 32'h0;
            cal_opt_ff <= 2'h0;
            srst_cnt_ff <= 8'h00;
            prdata_ff <= 32'h0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            link_ff <= nxt_link;
            cal_opt_ff <= nxt_cal_opt;
            srst_cnt_ff <= nxt_srst_cnt;
            prdata_ff <= nxt_prdata;
        end
    end

    // Link state machine
    always_comb begin
        nxt_link_st = link_st_ff;
        unique case (link_st_ff)
            LINK_HALT: if (serial_link_enable) begin
                nxt_link_st = LINK_WAIT_SYNC;
            end
            LINK_WAIT_SYNC: if (!sync_req_n) begin
                nxt_link_st = LINK_UP;
            end
            LINK_UP: if (sync_req_n) begin
                nxt_link_st = LINK_WAIT_SYNC;
            end
        endcase
        if (!serial_link_enable) begin
            nxt_link_st = LINK_HALT;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_st_ff <= LINK_HALT;
        end else begin
            link_st_ff <= nxt_link_st;
        end
    end

    // Calibration state machine; trigger edge is seen while idle only
    always_comb begin
        nxt_cal_st = cal_st_ff;
        nxt_cal_cnt = cal_cnt_ff;
        nxt_trig_q = calibration_trigger_bit;
        nxt_cal_done = cal_done_ff;
        unique case (cal_st_ff)
            CAL_HALT: if (calibration_enable) begin
                nxt_cal_st = CAL_IDLE;
            end
            CAL_IDLE: if (calibration_trigger_bit && !trig_q_ff) begin
                nxt_cal_st = CAL_RUN;
                nxt_cal_cnt = `ALSS_CAL_TIME;
                nxt_cal_done = 1'b0;
            end
            CAL_RUN: begin
                nxt_cal_cnt = cal_cnt_ff - 8'h01;
                if (cal_cnt_ff == 8'h01) begin
                    nxt_cal_st = CAL_IDLE;
                    nxt_cal_done = 1'b1;
                end
            end
        endcase
        if (!calibration_enable) begin
            nxt_cal_st = CAL_HALT;
            nxt_cal_cnt = 8'h00;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cal_st_ff <= CAL_HALT;
            cal_cnt_ff <= 8'h00;
            trig_q_ff <= 1'b0;
            cal_done_ff <= 1'b0;
        end else begin
            cal_st_ff <= nxt_cal_st;
            cal_cnt_ff <= nxt_cal_cnt;
            trig_q_ff <= nxt_trig_q;
            cal_done_ff <= nxt_cal_done;
        end
    end

    link_halt_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !serial_link_enable |=> !link_running)
        else $error("link not halted");
    cal_halt_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !calibration_enable |=> !cal_busy)
        else $error("calibration not halted");
    link_restart_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(serial_link_enable) |=> link_running && !link_data_valid)
        else $error("link did not restart");
    cal_restart_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cal_st_ff == CAL_HALT && calibration_enable) |=>
        cal_st_ff == CAL_IDLE)
        else $error("calibration did not restart");
    sync_follow_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (link_running && serial_link_enable && !sync_req_n) |=>
        link_data_valid || !serial_link_enable)
        else $error("link ignored sync");
    sync_src_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        link_ff[`ALSS_LINK_SYNC_SEL] |-> sync_req_n == timestamp_sync_n)
        else $error("wrong sync source");
    trig_start_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cal_st_ff == CAL_IDLE && calibration_enable &&
        $rose(calibration_trigger_bit)) |=> cal_busy ##64 !cal_busy)
        else $error("trigger edge missed");
    srst_wait_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(soft_reset_active) |-> soft_reset_active [*8])
        else $error("soft reset wait short");
    des_mode_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        dual_edge_sampling == !ctrl_ff[`ALSS_CTRL_DUAL])
        else $error("sampling mode wrong");

    // Link follows the receiver in both directions
    link_drop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (link_st_ff == LINK_UP && serial_link_enable && sync_req_n) |=>
        !link_data_valid)
        else $error("link stayed up without sync");
    sync_sel0_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !link_ff[`ALSS_LINK_SYNC_SEL] |->
        sync_req_n == single_ended_sync_input_n)
        else $error("wrong sync source");

    // Calibration run, abort and edge detection
    cal_abort_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cal_busy && !calibration_enable) |=> cal_st_ff == CAL_HALT)
        else $error("calibration not aborted");
    cal_done_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cal_busy && cal_cnt_ff == 8'h01 && calibration_enable) |=>
        !cal_busy && cal_done_ff)
        else $error("calibration did not finish");
    trig_level_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cal_st_ff == CAL_IDLE && calibration_enable &&
        calibration_trigger_bit && $past(calibration_trigger_bit)) |=>
        !cal_busy)
        else $error("calibration started without edge");
    cal_idle_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cal_st_ff == CAL_IDLE && calibration_enable &&
        !(calibration_trigger_bit && !trig_q_ff)) |=>
        cal_st_ff == CAL_IDLE)
        else $error("calibration left idle");

    // Soft reset restores defaults and times its wait
    srst_defaults_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr && paddr == `ALSS_OFS_CTRL && pwdata[`ALSS_CTRL_SRST]) |=>
        ctrl_ff == 32'h0000_0006 && link_ff == 32'h0 &&
        soft_reset_active)
        else $error("soft reset defaults wrong");
    srst_end_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (srst_cnt_ff == 8'h01 &&
        !(wr && paddr == `ALSS_OFS_CTRL && pwdata[`ALSS_CTRL_SRST])) |=>
        !soft_reset_active)
        else $error("soft reset wait long");

    // Register port behaviour
    ovr_follow_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr && paddr == `ALSS_OFS_CTRL && !pwdata[`ALSS_CTRL_SRST]) |=>
        overrange_enable == $past(pwdata[`ALSS_CTRL_OVERRANGE_ENABLE]))
        else $error("overrange enable wrong");
    link_cfg_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr && paddr == `ALSS_OFS_LINK) |=>
        link_ff[4:0] == $past(pwdata[4:0]))
        else $error("link format not stored");
    km1_cfg_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr && paddr == `ALSS_OFS_LINK) |=>
        link_ff[16:8] == $past(pwdata[16:8]))
        else $error("frame length not stored");
    unmapped_wr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr && !hit) |=> ctrl_ff == $past(ctrl_ff) &&
        link_ff == $past(link_ff))
        else $error("unmapped write took effect");
    rd_stable_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !rd |=> $stable(prdata))
        else $error("read data changed");
    err_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (acc && hit) |-> !pslverr)
        else $error("error on mapped address");
endmodule // alss_sequencer

// >>> tb/alss_sync_receiver.sv
// Link receiver model driving the two active-low sync requests
`timescale 1ns/1ns
module alss_sync_receiver (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Requests from the bench
    input wire logic req_se,
    input wire logic req_ts,
    // Sync lines, idle high
    output logic single_ended_sync_input_n,
    output logic timestamp_sync_n
);
    // Changes only on its own edge, as a real receiver would
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            single_ended_sync_input_n <= 1'b1;
            timestamp_sync_n <= 1'b1;
        end else begin
            single_ended_sync_input_n <= ~req_se;
            timestamp_sync_n <= ~req_ts;
        end
    end
endmodule // alss_sync_receiver

// >>> tb/tb_adc_link_startup_sequencer.sv
// Self-checking bench for the link startup sequencer
`timescale 1ns/1ns
`include "alss_consts.svh"
module tb_adc_link_startup_sequencer;
    logic ref_clk, pready, pslverr, err_s, se_n, ts_n;
    logic sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic req_se = 1'b0, req_ts = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic lnk_run, lnk_up, cal_busy, dual, ovr, srst_act;
    int num_errors = 0, samples_checked = 0;

    alss_sequencer alss_sequencer_inst (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .single_ended_sync_input_n(se_n), .timestamp_sync_n(ts_n),
        .link_running(lnk_run), .link_data_valid(lnk_up),
        .cal_busy(cal_busy), .dual_edge_sampling(dual),
        .overrange_enable(ovr), .soft_reset_active(srst_act));
    alss_sync_receiver alss_sync_receiver_inst (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .req_se(req_se), .req_ts(req_ts),
        .single_ended_sync_input_n(se_n), .timestamp_sync_n(ts_n));

    // Clock runs from time zero, before any soft reset
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Write lands and read data is taken at the edge that sees pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            $display("Error at %0t: got %h, expected %h", $time, 1'b0, 1'b1);
        end
        err_s = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task wrap_up;
        $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge ref_clk);
        num_errors++;
        wrap_up;
    end

    // Startup steps in the prescribed order
    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        tick(2);
        apb(1'b0, `ALSS_OFS_CTRL, 32'h0);
        chk(rd, 32'h6);
        chk(lnk_run, 1'b1);
        apb(1'b1, `ALSS_OFS_CTRL, 32'h7);
        chk(err_s, 1'b0);
        chk(srst_act, 1'b1);
        tick(`ALSS_SRST_CYCLES);
        chk(srst_act, 1'b0);
        apb(1'b0, `ALSS_OFS_CTRL, 32'h0);
        chk(rd, 32'h6);
        apb(1'b1, `ALSS_OFS_CTRL, 32'h4);
        tick(1);
        chk(lnk_run, 1'b0);
        apb(1'b1, `ALSS_OFS_CTRL, 32'h0);
        apb(1'b0, `ALSS_OFS_STAT, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, `ALSS_OFS_LINK, 32'h11F0A);
        apb(1'b0, `ALSS_OFS_LINK, 32'h0);
        chk(rd, 32'h11F0A);
        apb(1'b1, `ALSS_OFS_CAL, 32'h3);
        apb(1'b0, `ALSS_OFS_CAL, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, `ALSS_OFS_CTRL, 32'h4);
        apb(1'b1, `ALSS_OFS_CTRL, 32'hC);
        chk(ovr, 1'b1);
        apb(1'b1, `ALSS_OFS_CTRL, 32'hE);
        tick(1);
        chk(lnk_run, 1'b1);
        @(posedge ref_clk);
        req_se <= 1'b1;
        tick(4);
        chk(lnk_up, 1'b0);
        @(posedge ref_clk);
        req_ts <= 1'b1;
        tick(4);
        chk(lnk_up, 1'b1);
        apb(1'b0, `ALSS_OFS_STAT, 32'h0);
        chk(rd, 32'h6);
        apb(1'b1, `ALSS_OFS_CTRL, 32'h1E);
        tick(1);
        chk(cal_busy, 1'b1);
        tick(70);
        chk(cal_busy, 1'b0);
        apb(1'b0, `ALSS_OFS_STAT, 32'h0);
        chk(rd, 32'h26);
        apb(1'b1, `ALSS_OFS_CTRL, 32'h1E);
        tick(1);
        chk(cal_busy, 1'b0);
        apb(1'b1, `ALSS_OFS_CTRL, 32'hE);
        apb(1'b1, `ALSS_OFS_CTRL, 32'h1E);
        tick(1);
        chk(cal_busy, 1'b1);
        tick(70);
        chk(cal_busy, 1'b0);
        chk(dual, 1'b1);
        apb(1'b1, `ALSS_OFS_CTRL, 32'h3E);
        tick(1);
        chk(dual, 1'b0);
        @(posedge ref_clk);
        req_ts <= 1'b0;
        tick(4);
        chk(lnk_up, 1'b0);
        apb(1'b1, 12'h010, 32'hFFFFFFFF);
        chk(err_s, 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        chk(err_s, 1'b1);
        chk(rd, 32'h0);
        apb(1'b0, `ALSS_OFS_CTRL, 32'h0);
        chk(rd, 32'h3E);
        wrap_up;
    end
endmodule // tb_adc_link_startup_sequencer
